// [verilog/csl_lock.sv]
// code security lock: gates table reads, programming and verify
// assumes the lock bits byte is a static strap and the ea pin a live input, both outside the clock
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - with no lock bit programmed, verify reads back the stored code
// R2 - with a programmed key table, verify returns encrypted bytes
// R3 - lock one blocks external table reads of internal code bytes
// R4 - lock one samples the external access pin at reset and holds it
// R5 - lock one refuses all further programming of program memory
// R6 - both lock bits add a full verify disable to lock one effects
// R7 - the key table is 64 bytes, all ones until programmed
// R8 - only none, lock one, or both are defined combinations
// R9 - lock one is bit 0, lock two bit 1; zero enables protection
// R10 - the key follows the user code area; all ones means no encryption
// R11 - user code area is 8k, 16k or 32k bytes from address zero
// R12 - encrypted verify mixes each byte with the key byte at its low address
// R13 - lock bits are captured at reset and held until the next reset
module csl_lock #(
  parameter logic [16:0] AREA_SIZE = csl_pkg::CSL_AREA_8K
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps
  input wire logic [7:0] lock_bits_byte,
  input wire logic external_access_select,
  output logic ea_effective,
  // cpu fetch path
  input wire csl_pkg::csl_fetch_req_type fetch_req,
  output logic fetch_block,
  // programming and verify equipment
  input wire csl_pkg::csl_prog_req_type prog_req,
  output logic prog_grant,
  output logic prog_refused,
  input wire csl_pkg::csl_verify_req_type verify_req,
  output csl_pkg::csl_verify_ans_type verify_ans
);
  import csl_pkg::*;

  function automatic logic in_user_area(input logic [15:0] a);
    in_user_area = {1'b0, a} < AREA_SIZE; // [R11]
  endfunction : in_user_area

  csl_state_type state_reg;
  logic [7:0] lock_meta_reg;
  logic [7:0] lock_sync_reg;
  logic ea_meta_reg;
  logic ea_sync_reg;
  logic lock1_reg;
  logic lock2_reg;
  logic undef_reg;
  logic ea_reg;
  logic run;
  logic prog_refused_sticky_reg;
  logic key_refused_sticky_reg;
  logic key_arm_reg;
  logic [CSL_KEY_AW-1:0] key_idx_reg;
  logic [7:0] key_rd;
  logic [7:0] key_rd_v;
  logic key_programmed;
  logic key_wr;
  logic key_wr_ok;
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic mapped;
  logic [31:0] rd_next;
  logic [31:0] status_word;
  logic prog_grant_reg;
  logic prog_refused_reg;
  csl_verify_ans_type verify_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  assign run = (state_reg == CSL_ST_RUN);

  // straps cross in through two flops before anything looks at them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta_reg <= CSL_LOCK_BYTE_RST;
      lock_sync_reg <= CSL_LOCK_BYTE_RST;
      ea_meta_reg <= 1'b0;
      ea_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= lock_bits_byte;
      lock_sync_reg <= lock_meta_reg;
      ea_meta_reg <= external_access_select;
      ea_sync_reg <= ea_meta_reg;
    end
  end

  // the second sync flop shows the strap only two edges after release,
  // so capture waits for a third edge or it would latch the reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CSL_ST_SYNC0;
    end else begin
      unique case (state_reg)
        CSL_ST_SYNC0: state_reg <= CSL_ST_SYNC1;
        CSL_ST_SYNC1: state_reg <= CSL_ST_SYNC2;
        CSL_ST_SYNC2: state_reg <= CSL_ST_RUN;
        CSL_ST_RUN: state_reg <= CSL_ST_RUN;
      endcase
    end
  end

  // lock decisions are taken once and frozen; an undefined lock-two-only
  // setting is treated as fully locked, the safer way round
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock1_reg <= 1'b1;
      lock2_reg <= 1'b1;
      undef_reg <= 1'b0;
    end else if (state_reg == CSL_ST_SYNC2) begin
      lock1_reg <= !lock_sync_reg[CSL_LOCK_ONE_POS]
        || !lock_sync_reg[CSL_LOCK_TWO_POS]; // [R9] [R13] [R6] [R8]
      lock2_reg <= !lock_sync_reg[CSL_LOCK_TWO_POS]; // [R9] [R13]
      undef_reg <= lock_sync_reg[CSL_LOCK_ONE_POS]
        && !lock_sync_reg[CSL_LOCK_TWO_POS]; // [R8]
    end
  end

  // ea follows the pin unless lock one froze it at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_reg <= 1'b0;
    end else if (state_reg == CSL_ST_SYNC2) begin
      ea_reg <= ea_sync_reg;
    end else if (run && !lock1_reg) begin
      ea_reg <= ea_sync_reg;
    end
  end
  assign ea_effective = ea_reg; // [R4]

  // blocked while capture is pending so nothing leaks at start-up
  assign fetch_block = fetch_req.valid && fetch_req.table_read
    && fetch_req.from_external && in_user_area(fetch_req.addr)
    && (lock1_reg || !run); // [R3]

  // programming answer, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_grant_reg <= 1'b0;
      prog_refused_reg <= 1'b0;
    end else begin
      prog_grant_reg <= prog_req.valid && run && !lock1_reg;
      prog_refused_reg <= prog_req.valid && (lock1_reg || !run); // [R5]
    end
  end
  assign prog_grant = prog_grant_reg;
  assign prog_refused = prog_refused_reg;

  // verify answer; xnor with the key leaves a blank key transparent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verify_reg <= '0;
    end else begin
      verify_reg.valid <= verify_req.valid;
      verify_reg.denied <= verify_req.valid && (lock2_reg || !run); // [R6]
      if (!verify_req.valid || lock2_reg || !run
          || !in_user_area(verify_req.addr)) begin
        verify_reg.data <= CSL_HIDDEN_BYTE;
      end else if (key_programmed) begin
        verify_reg.data <= ~(verify_req.code_byte ^ key_rd_v); // [R2] [R12]
      end else begin
        verify_reg.data <= verify_req.code_byte; // [R1]
      end
    end
  end
  assign verify_ans = verify_reg;

  // key table is shared: verify reads by low address bits, apb writes by index
  csl_key_table #(
    .DEPTH(CSL_KEY_DEPTH),
    .AW(CSL_KEY_AW)
  ) csl_key_table_i (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(key_wr_ok),
    .wr_idx(key_idx_reg),
    .wr_data(pwdata[7:0]),
    .rd_idx(verify_req.addr[CSL_KEY_AW-1:0]),
    .rd_data(key_rd_v),
    .programmed(key_programmed)
  );
  assign key_rd = key_rd_v;

  // apb: zero wait states, read data captured in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite && !pslverr_reg;
  assign mapped = (paddr == CSL_STATUS_OFS) || (paddr == CSL_KEY_IDX_OFS)
    || (paddr == CSL_KEY_DATA_OFS) || (paddr == CSL_CTRL_OFS);
  assign key_wr = apb_wr && paddr == CSL_KEY_DATA_OFS;
  // key writes need the arm bit and no lock; the table is code memory too
  assign key_wr_ok = key_wr && key_arm_reg && run && !lock1_reg; // [R5]

  always_comb begin
    status_word = '0;
    status_word[CSL_ST_LOCK1_POS] = lock1_reg;
    status_word[CSL_ST_LOCK2_POS] = lock2_reg;
    status_word[CSL_ST_VERIFY_POS] = run && !lock2_reg;
    status_word[CSL_ST_ENCRYPT_POS] = key_programmed;
    status_word[CSL_ST_EA_POS] = ea_reg;
    status_word[CSL_ST_UNDEF_POS] = undef_reg;
    status_word[CSL_ST_RUN_POS] = run;
    status_word[CSL_ST_PROG_REF_POS] = prog_refused_sticky_reg;
    status_word[CSL_ST_KEY_REF_POS] = key_refused_sticky_reg;
  end

  always_comb begin
    rd_next = '0;
    unique case (paddr)
      CSL_STATUS_OFS: rd_next = status_word;
      CSL_KEY_IDX_OFS: rd_next[CSL_KEY_AW-1:0] = key_idx_reg;
      CSL_KEY_DATA_OFS: rd_next[7:0] = 8'h00;
      CSL_CTRL_OFS: rd_next[CSL_CTRL_KEY_ARM_POS] = key_arm_reg;
      default: rd_next = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= pwrite ? 32'h00000000 : rd_next;
      pslverr_reg <= !mapped;
    end
  end
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access && pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_idx_reg <= '0;
      key_arm_reg <= CSL_CTRL_KEY_ARM_RST;
    end else if (apb_wr && paddr == CSL_KEY_IDX_OFS) begin
      key_idx_reg <= pwdata[CSL_KEY_AW-1:0];
    end else if (apb_wr && paddr == CSL_CTRL_OFS) begin
      key_arm_reg <= pwdata[CSL_CTRL_KEY_ARM_POS];
    end else if (key_wr_ok) begin
      key_idx_reg <= key_idx_reg + 1'b1;
    end
  end

  // sticky refusals: write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_refused_sticky_reg <= 1'b0;
      key_refused_sticky_reg <= 1'b0;
    end else begin
      if (prog_refused_reg) begin
        prog_refused_sticky_reg <= 1'b1;
      end else if (apb_wr && paddr == CSL_STATUS_OFS
                   && pwdata[CSL_ST_PROG_REF_POS]) begin
        prog_refused_sticky_reg <= 1'b0;
      end
      if (key_wr && !key_wr_ok) begin
        key_refused_sticky_reg <= 1'b1;
      end else if (apb_wr && paddr == CSL_STATUS_OFS
                   && pwdata[CSL_ST_KEY_REF_POS]) begin
        key_refused_sticky_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_open_verify: assert property (verify_req.valid && run && !lock1_reg // [R1]
    && !key_programmed && in_user_area(verify_req.addr)
    |=> verify_ans.valid && !verify_ans.denied
    && verify_ans.data == $past(verify_req.code_byte))
    else $error("clear verify data mismatch");
  a_crypt_verify: assert property (verify_req.valid && run && !lock2_reg // [R2]
    && key_programmed && in_user_area(verify_req.addr)
    |=> verify_ans.data == ~($past(verify_req.code_byte) ^ $past(key_rd)))
    else $error("encrypted verify data mismatch");
  a_table_block: assert property (run && lock1_reg && fetch_req.valid // [R3]
    && fetch_req.table_read && fetch_req.from_external
    && in_user_area(fetch_req.addr) |-> fetch_block)
    else $error("external table read not blocked");
  a_ea_held: assert property (run && lock1_reg |=> $stable(ea_effective)) // [R4]
    else $error("held ea level changed");
  a_prog_refuse: assert property (prog_req.valid && run && lock1_reg // [R5]
    |=> prog_refused && !prog_grant)
    else $error("programming not refused under lock");
  a_verify_off: assert property (verify_req.valid && run && lock2_reg // [R6]
    |=> verify_ans.denied && verify_ans.data == CSL_HIDDEN_BYTE)
    else $error("verify not disabled");
  a_key_blank: assert property (!key_programmed |-> key_rd == CSL_KEY_BLANK) // [R7]
    else $error("unprogrammed key byte not all ones");
  a_undef_safe: assert property (undef_reg |-> lock1_reg && lock2_reg) // [R8]
    else $error("undefined lock combination left open");
  a_lock_frozen: assert property (run |=> $stable(lock1_reg) // [R13]
    && $stable(lock2_reg))
    else $error("lock state changed after capture");
  a_area_edge: assert property (verify_req.valid && run && !lock2_reg // [R11]
    && !in_user_area(verify_req.addr) |=> verify_ans.data == CSL_HIDDEN_BYTE)
    else $error("byte outside user area shown");

  c_open_verify: cover property (run && !lock1_reg && verify_req.valid);
  c_locked_fetch: cover property (run && lock1_reg && fetch_block);
  c_full_lock: cover property (run && lock2_reg && verify_ans.denied);
  c_key_write: cover property (key_wr_ok ##1 key_programmed);

endmodule : csl_lock
`default_nettype wire

// [verilog/csl_pkg.sv]
// constants, types and layouts shared by the code security lock block
// assumes a 32-bit apb register bus and a byte-wide program memory beside it
package csl_pkg;

  // apb register byte offsets
  localparam logic [7:0] CSL_STATUS_OFS = 8'h00;
  localparam logic [7:0] CSL_KEY_IDX_OFS = 8'h04;
  localparam logic [7:0] CSL_KEY_DATA_OFS = 8'h08;
  localparam logic [7:0] CSL_CTRL_OFS = 8'h0C;

  // status register fields
  localparam int CSL_ST_LOCK1_POS = 0;
  localparam int CSL_ST_LOCK2_POS = 1;
  localparam int CSL_ST_VERIFY_POS = 2;
  localparam int CSL_ST_ENCRYPT_POS = 3;
  localparam int CSL_ST_EA_POS = 4;
  localparam int CSL_ST_UNDEF_POS = 5;
  localparam int CSL_ST_RUN_POS = 6;
  localparam int CSL_ST_PROG_REF_POS = 7;
  localparam int CSL_ST_KEY_REF_POS = 8;

  // control register fields and reset value
  localparam int CSL_CTRL_KEY_ARM_POS = 0;
  localparam logic CSL_CTRL_KEY_ARM_RST = 1'b0;

  // lock bits byte layout, a zero bit means protection enabled
  localparam int CSL_LOCK_ONE_POS = 0;
  localparam int CSL_LOCK_TWO_POS = 1;
  localparam logic [7:0] CSL_LOCK_BYTE_RST = 8'hFF;

  // key table geometry and blank value
  localparam int CSL_KEY_DEPTH = 64;
  localparam int CSL_KEY_AW = 6;
  localparam logic [7:0] CSL_KEY_BLANK = 8'hFF;

  // user code area sizes per variant and the lock bits byte offset
  localparam logic [16:0] CSL_AREA_8K = 17'h02000;
  localparam logic [16:0] CSL_AREA_16K = 17'h04000;
  localparam logic [16:0] CSL_AREA_32K = 17'h08000;
  localparam logic [15:0] CSL_LOCK_BYTE_OFS = 16'h0020;

  // value returned for bytes that may not be shown
  localparam logic [7:0] CSL_HIDDEN_BYTE = 8'hFF;

  typedef struct packed {
    logic valid;
    logic table_read;
    logic from_external;
    logic [15:0] addr;
  } csl_fetch_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] code_byte;
  } csl_verify_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } csl_prog_req_type;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [7:0] data;
  } csl_verify_ans_type;

  typedef enum logic [1:0] {
    CSL_ST_SYNC0 = 2'b00,
    CSL_ST_SYNC1 = 2'b01,
    CSL_ST_SYNC2 = 2'b11,
    CSL_ST_RUN = 2'b10
  } csl_state_type;

endpackage : csl_pkg

// [verilog/csl_key_table.sv]
// 64-byte encryption key table, blank (all ones) until written
// assumes writes are already checked against the lock state by the caller
`timescale 1ns/100ps
`default_nettype none
module csl_key_table #(
  parameter int DEPTH = csl_pkg::CSL_KEY_DEPTH,
  parameter int AW = csl_pkg::CSL_KEY_AW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic programmed
);
  import csl_pkg::*;

  logic [7:0] key_mem_reg [DEPTH];
  logic programmed_reg;

  // table starts blank so an unprogrammed part verifies in clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        key_mem_reg[i] <= CSL_KEY_BLANK; // [R7]
      end
    end else if (wr_en) begin
      key_mem_reg[wr_idx] <= wr_data; // [R10]
    end
  end

  // any non-blank byte turns encryption on; it never turns back off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programmed_reg <= 1'b0;
    end else if (wr_en && wr_data != CSL_KEY_BLANK) begin
      programmed_reg <= 1'b1; // [R2]
    end
  end

  assign rd_data = key_mem_reg[rd_idx];
  assign programmed = programmed_reg;

endmodule : csl_key_table
`default_nettype wire

// [verilog/csl_lock_fix_note.sv]
// no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [testbench/csl_code_mem.sv]
// program memory model: answers the verify path with the stored code byte
// assumes the bench presents the verify address; content is a fixed pattern
`timescale 1ns/100ps
`default_nettype none
module csl_code_mem (
  // lookup
  input wire logic [15:0] addr,
  output logic [7:0] code_byte
);
  // pattern differs per address so a wrong key index shows up
  assign code_byte = addr[7:0] ^ addr[15:8] ^ 8'h5A;
endmodule : csl_code_mem
`default_nettype wire

// [testbench/csl_lock_bench.sv]
// self-checking bench for the code security lock, apb plus strap sweep
// assumes csl_pkg, csl_lock and csl_code_mem are compiled before it
`timescale 1ns/100ps
`default_nettype none
module csl_lock_bench;
  import csl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] lock_bits_byte = 8'hFF;
  logic external_access_select = 1'b1;
  logic ea_effective;
  csl_fetch_req_type fetch_req = '0;
  logic fetch_block;
  csl_prog_req_type prog_req = '0;
  logic prog_grant;
  logic prog_refused;
  csl_verify_req_type verify_req;
  csl_verify_ans_type verify_ans;
  logic v_valid = 1'b0;
  logic [15:0] v_addr = 16'h0;
  logic [7:0] code_byte;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;

  always #2 pclk = ~pclk;
  assign verify_req = '{valid: v_valid, addr: v_addr, code_byte: code_byte};

  csl_lock #(.AREA_SIZE(CSL_AREA_8K)) csl_lock_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lock_bits_byte(lock_bits_byte),
    .external_access_select(external_access_select),
    .ea_effective(ea_effective), .fetch_req(fetch_req),
    .fetch_block(fetch_block), .prog_req(prog_req),
    .prog_grant(prog_grant), .prog_refused(prog_refused),
    .verify_req(verify_req), .verify_ans(verify_ans)
  );
  csl_code_mem csl_code_mem_i (.addr(v_addr), .code_byte(code_byte));

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mem_byte

  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // a hung handshake or poll would otherwise run forever
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic vfy(input logic [15:0] a, input logic den,
                     input logic [7:0] dat);
    @(posedge pclk);
    v_valid <= 1'b1;
    v_addr <= a;
    @(posedge pclk);
    v_valid <= 1'b0;
    #1;
    chk(32'({verify_ans.valid, verify_ans.denied, verify_ans.data}),
        32'({1'b1, den, dat}));
  endtask : vfy

  task automatic run_combo(input logic [7:0] lb);
    logic l1;
    logic l2;
    int k;
    l1 = ~lb[0] | ~lb[1];
    l2 = ~lb[1];
    k = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    lock_bits_byte <= lb;
    external_access_select <= 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    do begin
      apb(CSL_STATUS_OFS, 1'b0, 32'h0);
      k++;
    end while (rd[CSL_ST_RUN_POS] !== 1'b1 && k < 20);
    chk(32'(rd[CSL_ST_RUN_POS]), 32'h1);
    chk(32'(rd[CSL_ST_UNDEF_POS]), 32'(lb[0] & ~lb[1]));
    chk(32'(rd[CSL_ST_LOCK1_POS]), 32'(l1));
    chk(32'(rd[CSL_ST_LOCK2_POS]), 32'(l2));
    chk(32'(rd[CSL_ST_VERIFY_POS]), 32'({~l2}));
    chk(32'(rd[CSL_ST_EA_POS]), 32'h1);
    apb(CSL_CTRL_OFS, 1'b0, 32'h0);
    chk(32'(rd[0]), 32'(CSL_CTRL_KEY_ARM_RST));
    // internal table read from external code, then from internal code
    fetch_req <= '{valid: 1'b1, table_read: 1'b1, from_external: 1'b1,
                   addr: 16'h0100};
    @(posedge pclk);
    #1;
    chk(32'(fetch_block), 32'(l1));
    @(posedge pclk);
    fetch_req.from_external <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'(fetch_block), 32'h0);
    @(posedge pclk);
    fetch_req <= '0;
    prog_req <= '{valid: 1'b1, addr: 16'h0040};
    @(posedge pclk);
    prog_req <= '0;
    #1;
    chk(32'({prog_grant, prog_refused}), 32'({~l1, l1}));
    vfy(16'h0123, l2, l2 ? CSL_HIDDEN_BYTE : mem_byte(16'h0123));
    // pin moves after reset; held value must survive under lock one
    @(posedge pclk);
    external_access_select <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
    chk(32'(ea_effective), 32'(l1));
    apb(CSL_CTRL_OFS, 1'b1, 32'h1);
    apb(CSL_KEY_DATA_OFS, 1'b1, 32'h3C);
    apb(CSL_STATUS_OFS, 1'b0, 32'h0);
    chk(32'(rd[CSL_ST_KEY_REF_POS]), 32'(l1));
    chk(32'(rd[CSL_ST_ENCRYPT_POS]), 32'({~l1}));
    chk(32'(rd[CSL_ST_PROG_REF_POS]), 32'(l1));
    if (!l1) begin
      vfy(16'h0000, 1'b0, ~(mem_byte(16'h0000) ^ 8'h3C));
      vfy(16'h0041, 1'b0, mem_byte(16'h0041));
      vfy(16'h0040, 1'b0, ~(mem_byte(16'h0040) ^ 8'h3C));
      apb(CSL_KEY_IDX_OFS, 1'b1, 32'h3F);
      apb(CSL_KEY_DATA_OFS, 1'b1, 32'hA5);
      apb(CSL_KEY_IDX_OFS, 1'b0, 32'h0);
      chk(rd & 32'h3F, 32'h0);
      vfy(16'h013F, 1'b0, ~(mem_byte(16'h013F) ^ 8'hA5));
      vfy(16'h1FFF, 1'b0, ~(mem_byte(16'h1FFF) ^ 8'hA5));
      vfy(16'h2000, 1'b0, CSL_HIDDEN_BYTE);
      apb(8'h10, 1'b0, 32'h0);
      chk(32'(er), 32'h1);
      apb(CSL_KEY_DATA_OFS, 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
  endtask : run_combo

  initial begin
    run_combo(8'hFF);
    run_combo(8'hFE);
    run_combo(8'hFC);
    run_combo(8'hFD);
    run_combo(8'hFF);
    tally_and_finish();
  end
endmodule : csl_lock_bench
`default_nettype wire
